// file: include/bor_seq_pkg.sv
package bor_seq_pkg;
    // Register byte offsets on the Wishbone bus
    localparam logic [4:0] ADDR_CAUSE = 5'h00;
    localparam logic [4:0] ADDR_CFG = 5'h04;
    localparam logic [4:0] ADDR_IRQ_STAT = 5'h08;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h0c;
    localparam logic [4:0] ADDR_STATUS = 5'h10;
    localparam int unsigned ADDR_W = 5;
    // Reset cause register: brown-out flag position
    localparam int unsigned CAUSE_BOR_BIT = 1;
    // Status register: lock flag position (read-only view)
    localparam int unsigned OSC_LOCK_BIT = 5;
    // Config register field positions
    localparam int unsigned CFG_OSCSEL_LSB = 0;
    localparam int unsigned CFG_POSC_LSB = 4;
    localparam int unsigned CFG_PLL_BIT = 8;
    localparam int unsigned CFG_POWERUP_TIMER_LSB = 16;
    localparam logic [2:0] OSCSEL_RESET = 3'h7;
    localparam logic [1:0] POSC_RESET = 2'h3;
    localparam logic [1:0] POSC_XTAL = 2'h1;
    localparam logic [1:0] POSC_DISABLED = 2'h3;
    localparam logic [2:0] OSCSEL_PRIMARY = 3'h2;
    localparam logic [2:0] OSCSEL_PRIMARY_PLL = 3'h3;
    localparam logic [15:0] POWERUP_TIMER_RESET = 16'h0040;
    // Interrupt bits
    localparam int unsigned IRQ_BOR = 0;
    localparam int unsigned IRQ_READY = 1;
    // Timing
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned FAILSAFE_US = 100;
    localparam int unsigned FAILSAFE_CYC = (FAILSAFE_US * (CLK_HZ / 1000000) > 0) ?
        FAILSAFE_US * (CLK_HZ / 1000000) : 1;
    localparam int unsigned OST_CYC_DEF = 1024;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned PULSE_CYC = 4;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_PULSE = 2'b01,
        ST_HOLD = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [2:0] osc_select_cfg;
        logic [1:0] primary_osc_mode_cfg;
        logic pll_en;
        logic [15:0] powerup_delay;
    } cfg_t;

    typedef struct packed {
        seq_state_t st;
        cfg_t cfg;
        logic [2:0] clk_src;
        logic use_osc;
        logic use_pll;
        logic [CNT_W-1:0] ost_cnt;
        logic [CNT_W-1:0] powerup_timer_cnt;
        logic [2:0] pulse_cnt;
        logic clk_hold;
        logic core_rst;
        logic bor_flag;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic irq;
        logic ack;
        logic [31:0] rdata;
        logic bor_s1;
        logic bor_s2;
        logic lock_s1;
        logic lock_s2;
    } seq_regs_t;
endpackage

// file: src/brownout_reset_sequencer.sv
module brownout_reset_sequencer #(
    parameter int unsigned OST_CYC = bor_seq_pkg::OST_CYC_DEF,
    parameter int unsigned FAILSAFE_CYCLES = bor_seq_pkg::FAILSAFE_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_brownout_det,
    input wire logic i_pll_lock,
    input wire logic i_sleep,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [bor_seq_pkg::ADDR_W-1:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    output logic o_device_rst,
    output logic o_clk_hold,
    output logic [2:0] o_clk_src,
    output logic o_irq
);
    localparam int unsigned CNT_W = bor_seq_pkg::CNT_W;

    bor_seq_pkg::seq_regs_t q, d;

    // Pack the config register for reading
    function automatic logic [31:0] cfg_word(input bor_seq_pkg::cfg_t c);
        logic [31:0] w;
        w = 32'h0;
        w[bor_seq_pkg::CFG_OSCSEL_LSB +: 3] = c.osc_select_cfg;
        w[bor_seq_pkg::CFG_POSC_LSB +: 2] = c.primary_osc_mode_cfg;
        w[bor_seq_pkg::CFG_PLL_BIT] = c.pll_en;
        w[bor_seq_pkg::CFG_POWERUP_TIMER_LSB +: 16] = c.powerup_delay;
        return w;
    endfunction

    // Byte-lane merge of a write into a word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic bor_rise;
    logic wr;
    logic rd;
    logic [31:0] wmask;
    logic [31:0] cfg_new;

    // Next-state logic for the sequencer, flags and bus slave
    always_comb begin
        d = q;
        d.bor_s1 = i_brownout_det;
        d.bor_s2 = q.bor_s1;
        d.lock_s1 = i_pll_lock;
        d.lock_s2 = q.lock_s1;
        bor_rise = q.bor_s2;
        wr = i_wb_cyc && i_wb_stb && i_wb_we && !q.ack;
        rd = i_wb_cyc && i_wb_stb && !i_wb_we && !q.ack;
        wmask = merge(32'h0, 32'hffffffff, i_wb_sel);
        cfg_new = merge(cfg_word(q.cfg), i_wb_dat, i_wb_sel);
        d.ack = i_wb_cyc && i_wb_stb && !q.ack;
        d.rdata = 32'h0;

        // Register writes
        if (wr) begin
            case (i_wb_adr[bor_seq_pkg::ADDR_W-1:0])
                5'(bor_seq_pkg::ADDR_CAUSE): begin
                    if (wmask[bor_seq_pkg::CAUSE_BOR_BIT] &&
                        !i_wb_dat[bor_seq_pkg::CAUSE_BOR_BIT]) begin
                        d.bor_flag = 1'b0;
                    end
                end
                5'(bor_seq_pkg::ADDR_CFG): begin
                    d.cfg.osc_select_cfg = cfg_new[bor_seq_pkg::CFG_OSCSEL_LSB +: 3];
                    d.cfg.primary_osc_mode_cfg = cfg_new[bor_seq_pkg::CFG_POSC_LSB +: 2];
                    d.cfg.pll_en = cfg_new[bor_seq_pkg::CFG_PLL_BIT];
                    d.cfg.powerup_delay = cfg_new[bor_seq_pkg::CFG_POWERUP_TIMER_LSB +: 16];
                end
                5'(bor_seq_pkg::ADDR_IRQ_STAT): begin
                    d.irq_stat = q.irq_stat & ~(i_wb_dat[1:0] & wmask[1:0]);
                end
                5'(bor_seq_pkg::ADDR_IRQ_MASK): begin
                    d.irq_mask = (q.irq_mask & ~wmask[1:0]) | (i_wb_dat[1:0] & wmask[1:0]);
                end
                default: begin
                end
            endcase
        end

        // Register reads; unmapped addresses read as zero
        if (rd) begin
            case (i_wb_adr[bor_seq_pkg::ADDR_W-1:0])
                5'(bor_seq_pkg::ADDR_CAUSE): begin
                    d.rdata[bor_seq_pkg::CAUSE_BOR_BIT] = q.bor_flag;
                end
                5'(bor_seq_pkg::ADDR_CFG): d.rdata = cfg_word(q.cfg);
                5'(bor_seq_pkg::ADDR_IRQ_STAT): d.rdata[1:0] = q.irq_stat;
                5'(bor_seq_pkg::ADDR_IRQ_MASK): d.rdata[1:0] = q.irq_mask;
                5'(bor_seq_pkg::ADDR_STATUS): begin
                    d.rdata[bor_seq_pkg::OSC_LOCK_BIT] = q.lock_s2;
                    d.rdata[1:0] = q.st;
                    d.rdata[4:2] = q.clk_src;
                end
                default: d.rdata = 32'h0;
            endcase
        end

        // Sequencer; brown-out is honoured in every state and in sleep
        case (q.st)
            bor_seq_pkg::ST_RUN: begin
                d.clk_hold = 1'b0;
                d.core_rst = 1'b0;
            end
            bor_seq_pkg::ST_PULSE: begin
                d.core_rst = 1'b1;
                d.clk_hold = 1'b1;
                if (q.pulse_cnt != 3'h0) begin
                    d.pulse_cnt = q.pulse_cnt - 3'h1;
                end else if (!q.bor_s2) begin
                    d.st = bor_seq_pkg::ST_HOLD;
                end
            end
            bor_seq_pkg::ST_HOLD: begin
                d.core_rst = 1'b1;
                if (q.use_osc && q.ost_cnt != '0) begin
                    d.ost_cnt = q.ost_cnt - 1'b1;
                end
                if (q.powerup_timer_cnt != '0) begin
                    d.powerup_timer_cnt = q.powerup_timer_cnt - 1'b1;
                end
                // Clock held until start-up timer and PLL lock are both done
                d.clk_hold = (q.use_osc && q.ost_cnt != '0) ||
                             (q.use_pll && !q.lock_s2);
                if (!d.clk_hold && q.powerup_timer_cnt == '0) begin
                    d.st = bor_seq_pkg::ST_RUN;
                    d.core_rst = 1'b0;
                    d.irq_stat[bor_seq_pkg::IRQ_READY] = 1'b1;
                end
            end
            default: d.st = bor_seq_pkg::ST_RUN;
        endcase

        // Brown-out entry wins over everything, sleep included
        if (bor_rise) begin
            d.st = bor_seq_pkg::ST_PULSE;
            d.core_rst = 1'b1;
            d.clk_hold = 1'b1;
            d.pulse_cnt = 3'(bor_seq_pkg::PULSE_CYC - 1);
            d.clk_src = q.cfg.osc_select_cfg;
            d.use_osc = q.cfg.primary_osc_mode_cfg != bor_seq_pkg::POSC_DISABLED;
            d.use_pll = q.cfg.pll_en ||
                        q.cfg.osc_select_cfg == bor_seq_pkg::OSCSEL_PRIMARY_PLL;
            d.ost_cnt = CNT_W'(OST_CYC);
            if (q.cfg.powerup_delay == 16'h0 &&
                q.cfg.primary_osc_mode_cfg == bor_seq_pkg::POSC_XTAL) begin
                d.powerup_timer_cnt = CNT_W'(FAILSAFE_CYCLES);
            end else begin
                d.powerup_timer_cnt = q.cfg.powerup_delay;
            end
            d.bor_flag = 1'b1;
            d.irq_stat[bor_seq_pkg::IRQ_BOR] = 1'b1;
        end
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    // State register; the brown-out flag is not cleared by reset
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            q <= '0;
            q.cfg.osc_select_cfg <= bor_seq_pkg::OSCSEL_RESET;
            q.cfg.primary_osc_mode_cfg <= bor_seq_pkg::POSC_RESET;
            q.cfg.powerup_delay <= bor_seq_pkg::POWERUP_TIMER_RESET;
            q.clk_src <= bor_seq_pkg::OSCSEL_RESET;
            q.bor_flag <= q.bor_flag;
        end else begin
            q <= d;
        end
    end

    assign o_wb_ack = q.ack;
    assign o_wb_dat = q.rdata;
    assign o_device_rst = q.core_rst;
    assign o_clk_hold = q.clk_hold;
    assign o_clk_src = q.clk_src;
    assign o_irq = q.irq;

    sequence s_bor_seen;
        q.bor_s2;
    endsequence
    sequence s_pulse_on;
        o_device_rst && o_clk_hold;
    endsequence

    AST_BOR_PULSE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_bor_seen |=> s_pulse_on) else $error("Brown-out gave no reset pulse");
    AST_CLK_SRC: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        q.bor_s2 |=> o_clk_src == $past(q.cfg.osc_select_cfg))
        else $error("Clock source not taken from config");
    AST_OST_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (q.st == bor_seq_pkg::ST_HOLD && q.use_osc && q.ost_cnt > 1) |=> o_clk_hold)
        else $error("Clock released before start-up timer ended");
    AST_PLL_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (q.st == bor_seq_pkg::ST_HOLD && q.use_pll && !q.lock_s2 && !q.bor_s2)
        |=> o_clk_hold) else $error("Clock released without PLL lock");
    AST_POWERUP_TIMER: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (q.st == bor_seq_pkg::ST_HOLD && q.powerup_timer_cnt != '0) |=> o_device_rst)
        else $error("Internal reset released before power-up delay");
    AST_FAILSAFE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (q.bor_s2 && q.cfg.powerup_delay == 16'h0 &&
         q.cfg.primary_osc_mode_cfg == bor_seq_pkg::POSC_XTAL)
        |=> q.powerup_timer_cnt == CNT_W'(FAILSAFE_CYCLES)) else $error("Fail-safe delay not loaded");
    AST_FLAG_SET: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        q.bor_s2 |=> q.bor_flag) else $error("Brown-out flag not set");
    AST_SLEEP: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_sleep && q.bor_s2) |=> q.st == bor_seq_pkg::ST_PULSE)
        else $error("Brown-out ignored in sleep");
    AST_FLAG_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (q.bor_flag && !(i_wb_cyc && i_wb_stb && i_wb_we)) |=> q.bor_flag)
        else $error("Brown-out flag lost without a write");

    // Bus request taken and its one-cycle answer
    sequence s_bus_taken;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence s_ack_pulse;
        o_wb_ack ##1 !o_wb_ack;
    endsequence
    // Entry into the reset pulse and the end of the hold phase
    sequence s_pulse_start;
        (q.st != bor_seq_pkg::ST_PULSE) ##1 (q.st == bor_seq_pkg::ST_PULSE);
    endsequence
    sequence s_hold_done;
        (q.st == bor_seq_pkg::ST_HOLD) ##1 (q.st == bor_seq_pkg::ST_RUN);
    endsequence

    // Every taken request is acked for exactly one cycle
    AST_BUS_ACK: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_bus_taken |=> s_ack_pulse) else $error("Bus request not acked for one cycle");

    // No ack without a request
    AST_ACK_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !(i_wb_cyc && i_wb_stb) |=> !o_wb_ack) else $error("Ack without a request");

    // Write answers carry zero data
    AST_WR_DAT_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        wr |=> o_wb_dat == 32'h0) else $error("Write answer carried data");

    // Config write lands in the oscillator select field
    AST_CFG_WR: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (wr && i_wb_adr == bor_seq_pkg::ADDR_CFG && i_wb_sel[0])
        |=> q.cfg.osc_select_cfg == $past(i_wb_dat[2:0])) else $error("Config write lost");

    // Mask write lands
    AST_MASK_WR: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (wr && i_wb_adr == bor_seq_pkg::ADDR_IRQ_MASK && i_wb_sel[0])
        |=> q.irq_mask == $past(i_wb_dat[1:0])) else $error("Mask write lost");

    // Writing zero to the brown-out flag clears it unless a brown-out is pending
    AST_FLAG_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (wr && i_wb_adr == bor_seq_pkg::ADDR_CAUSE && i_wb_sel[0] &&
         !i_wb_dat[bor_seq_pkg::CAUSE_BOR_BIT] && !q.bor_s2) |=> !q.bor_flag)
        else $error("Brown-out flag not cleared by software");

    // Writing one to a status bit clears it unless the event repeats
    AST_STAT_W1C: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (wr && i_wb_adr == bor_seq_pkg::ADDR_IRQ_STAT && i_wb_sel[0] &&
         i_wb_dat[bor_seq_pkg::IRQ_BOR] && !q.bor_s2) |=> !q.irq_stat[bor_seq_pkg::IRQ_BOR])
        else $error("Status bit not cleared by write one");

    // Brown-out raises its status bit
    AST_BOR_IRQ: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        q.bor_s2 |=> q.irq_stat[bor_seq_pkg::IRQ_BOR]) else $error("Brown-out status not set");

    // End of the sequence raises its status bit
    AST_READY_IRQ: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_hold_done |-> q.irq_stat[bor_seq_pkg::IRQ_READY]) else $error("Done status not set");

    // Interrupt line follows the unmasked status bits
    AST_IRQ_LEVEL: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        o_irq == (|(q.irq_stat & q.irq_mask))) else $error("Interrupt level wrong");

    // Reset pulse lasts at least four cycles
    AST_PULSE_MIN: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_pulse_start |-> o_device_rst [*4]) else $error("Reset pulse too short");

    // Running with no brown-out leaves clock and device free
    AST_RUN_FREE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (q.st == bor_seq_pkg::ST_RUN && !q.bor_s2) |=> (!o_device_rst && !o_clk_hold))
        else $error("Reset or hold while running");

    // Internal reset never releases before the clock does
    AST_RST_ORDER: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        $fell(o_device_rst) |-> !o_clk_hold) else $error("Reset released under clock hold");

    // Start-up timer loaded on brown-out
    AST_OST_LOAD: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        q.bor_s2 |=> q.ost_cnt == CNT_W'(OST_CYC)) else $error("Start-up timer not loaded");

    // Disabled primary oscillator skips the start-up timer
    AST_OST_SKIP: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (q.bor_s2 && q.cfg.primary_osc_mode_cfg == bor_seq_pkg::POSC_DISABLED)
        |=> !q.use_osc) else $error("Start-up timer used without oscillator");

    // Clock released only after the start-up timer ran out
    AST_OST_DONE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        ($fell(o_clk_hold) && q.use_osc) |-> q.ost_cnt == '0)
        else $error("Clock released with timer running");

    // PLL source selects the lock wait
    AST_PLL_SEL: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (q.bor_s2 && q.cfg.osc_select_cfg == bor_seq_pkg::OSCSEL_PRIMARY_PLL) |=> q.use_pll)
        else $error("PLL source without lock wait");

    // Clock released with the PLL only after lock was seen
    AST_PLL_WAIT: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        ($fell(o_clk_hold) && q.use_pll) |-> $past(q.lock_s2))
        else $error("Clock released before lock");

    // Power-up delay loaded from config when non-zero
    AST_POWERUP_TIMER_LOAD: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (q.bor_s2 && q.cfg.powerup_delay != 16'h0) |=> q.powerup_timer_cnt == $past(q.cfg.powerup_delay))
        else $error("Power-up delay not loaded");

    // Clock source changes only on brown-out
    AST_SRC_STABLE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !q.bor_s2 |=> $stable(o_clk_src)) else $error("Clock source changed without brown-out");
endmodule

// file: verif/test_brownout_reset_sequencer.sv
module test_brownout_reset_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] A_CAUSE = 5'(bor_seq_pkg::ADDR_CAUSE);
    localparam logic [4:0] A_CFG = 5'(bor_seq_pkg::ADDR_CFG);
    localparam logic [4:0] A_STAT = 5'(bor_seq_pkg::ADDR_IRQ_STAT);
    localparam logic [4:0] A_MASK = 5'(bor_seq_pkg::ADDR_IRQ_MASK);
    localparam logic [4:0] A_SR = 5'(bor_seq_pkg::ADDR_STATUS);
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic det = 1'b0;
    logic lock = 1'b0;
    logic slp = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'hf;
    logic ack, dev_rst, hold, irq;
    logic [31:0] rdat;
    logic [2:0] src;
    logic rd_pend = 1'b0;
    logic [31:0] exp_q[$];
    string name_q[$];
    int fails = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h3f89;
    // Per-case config, mask, lock moment, release windows and expected results
    logic [31:0] cfgs [3] = '{32'h0000_0012, 32'h0018_0013, 32'h0018_0037};
    logic [31:0] masks [3] = '{32'h3, 32'h2, 32'h0};
    logic [31:0] stats [3] = '{32'h28, 32'h2c, 32'h3c};
    int lk [3] = '{0, 40, 0};
    int hmin [3] = '{8, 40, 0};
    int hmax [3] = '{20, 48, 10};
    int rmin [3] = '{16, 40, 24};
    int rmax [3] = '{30, 52, 36};
    logic [2:0] srcs [3] = '{3'h2, 3'h3, 3'h7};
    logic irqs [3] = '{1'b1, 1'b1, 1'b0};

    always #20 i_sys_clk = ~i_sys_clk;

    brownout_reset_sequencer #(.OST_CYC(8), .FAILSAFE_CYCLES(16)) dut (
        .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_brownout_det(det),
        .i_pll_lock(lock), .i_sleep(slp), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
        .o_wb_ack(ack), .o_wb_dat(rdat), .o_device_rst(dev_rst),
        .o_clk_hold(hold), .o_clk_src(src), .o_irq(irq));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", what, e, s);
            fails++;
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Classic single Wishbone cycle; a read notes its expected word in the queue
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, input string nm);
        int n;
        @(posedge i_sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= w ? d : 32'h0;
        if (!w) begin
            exp_q.push_back(d);
            name_q.push_back(nm);
            rd_pend <= 1'b1;
        end
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) check("bus ack", 32'h1, 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
        rd_pend <= 1'b0;
    endtask

    // Watches acked reads and compares against the oldest note
    always @(posedge i_sys_clk) begin
        if (ack === 1'b1 && rd_pend === 1'b1 && exp_q.size() > 0) begin
            check(name_q.pop_front(), exp_q.pop_front(), rdat);
        end
    end

    // One brown-out in sleep, then release timing, flags and clearing
    task automatic run(input int i);
        int n, th, tr, k;
        wb(1'b1, A_CFG, cfgs[i], "");
        wb(1'b1, A_MASK, masks[i], "");
        @(posedge i_sys_clk);
        lock <= (lk[i] == 0);
        slp <= 1'b1;
        det <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        check("device reset", 32'h1, 32'(dev_rst));
        check("clock hold", 32'h1, 32'(hold));
        k = 4 + int'(xs() % 4);
        repeat (k) @(posedge i_sys_clk);
        det <= 1'b0;
        th = -1;
        tr = -1;
        for (n = 0; n < 200; n++) begin
            @(posedge i_sys_clk);
            if (n == lk[i]) lock <= 1'b1;
            @(negedge i_sys_clk);
            if (th < 0 && hold === 1'b0) th = n;
            if (tr < 0 && dev_rst === 1'b0) tr = n;
        end
        check("hold release", 32'h1, 32'(th >= hmin[i] && th <= hmax[i]));
        check("reset release", 32'h1, 32'(tr >= rmin[i] && tr <= rmax[i]));
        check("clock source", 32'(srcs[i]), 32'(src));
        check("irq level", 32'(irqs[i]), 32'(irq));
        wb(1'b0, A_SR, stats[i], "status");
        wb(1'b0, A_STAT, 32'h3, "irq status");
        wb(1'b1, A_STAT, 32'h1, "");
        wb(1'b0, A_STAT, 32'h2, "irq status w1c");
        @(posedge i_sys_clk);
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        wb(1'b0, A_CAUSE, 32'h2, "cause after reset");
        wb(1'b1, A_CAUSE, 32'h2, "");
        wb(1'b0, A_CAUSE, 32'h2, "cause write one");
        wb(1'b1, A_CAUSE, 32'h0, "");
        wb(1'b0, A_CAUSE, 32'h0, "cause cleared");
    endtask

    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        @(negedge i_sys_clk);
        check("reset clock source", 32'h7, 32'(src));
        check("reset device reset", 32'h0, 32'(dev_rst));
        wb(1'b1, A_CAUSE, 32'h0, "");
        wb(1'b0, A_CAUSE, 32'h0, "cause initial clear");
        wb(1'b0, 5'h14, 32'h0, "unmapped read");
        wb(1'b1, 5'h18, xs(), "");
        wb(1'b0, A_CFG, 32'h0040_0037, "config reset");
        for (int i = 0; i < 3; i++) run(i);
        final_report();
    end

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fails++;
        final_report();
    end
endmodule
